// >>> rtl/dual_counter_input_unit.sv
// Purpose: four input pins serving as plain inputs and two counters
// Assumes: apb slave, zero wait states, pins asynchronous to pclk
// Notes:   capture configuration steals line four and stops counter b
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps

module dual_counter_input_unit
  import counter_unit_pkg::*;
#(
  parameter int unsigned COUNT_WIDTH = 32,
  parameter int unsigned FILTER_CYC  = FAST_CYCLES,
  parameter int unsigned TICK_CYC    = TICK_CYCLES,
  parameter int unsigned DELAY_TICKS = PLAIN_DELAY_TCK
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // field input pins
  input  wire logic        count_input_one,
  input  wire logic        count_input_two,
  input  wire logic        count_input_three,
  input  wire logic        count_input_four,
  // indicators and interrupt
  output logic [3:0]       status_led,
  output logic             irq
);

  // refuse settings the logic cannot serve
  // a filter as long as the minimum pulse would swallow legal pulses
  generate
    if (COUNT_WIDTH < 2 || COUNT_WIDTH > 32) begin : g_bad_width
      $error("COUNT_WIDTH must lie in 2..32");
    end
    if (FILTER_CYC < 1 || FILTER_CYC >= MIN_PULSE_CYC) begin : g_bad_filt
      $error("FILTER_CYC must be 1 or more and below the minimum pulse");
    end
    if (TICK_CYC < 2 || DELAY_TICKS < 1) begin : g_bad_delay
      $error("TICK_CYC must be 2 or more and DELAY_TICKS 1 or more");
    end
  endgenerate

  // tick and delay counter widths, sized from the parameters
  localparam int unsigned TW = $clog2(TICK_CYC);
  localparam int unsigned DW = $clog2(DELAY_TICKS + 1);
  localparam logic [TW-1:0] TICK_LAST  = TW'(TICK_CYC - 1);
  localparam logic [DW-1:0] DELAY_LAST = DW'(DELAY_TICKS - 1);
  // line positions inside the gathered pin vector
  localparam int unsigned LINE_ONE   = 0;
  localparam int unsigned LINE_TWO   = 1;
  localparam int unsigned LINE_THREE = 2;
  localparam int unsigned LINE_FOUR  = 3;

  // pins gathered for the loops below
  logic [3:0]             pins;
  logic [3:0]             fast_level;
  // plain input path
  logic [TW-1:0]          tick_cnt_reg;
  logic                   tick_reg;
  logic [DW-1:0]          delay_cnt_reg [4];
  logic [3:0]             plain_input_line_reg;
  logic [3:0]             led_reg;
  // configuration and state
  logic [CTRL_WIDTH-1:0]  ctrl_reg;
  logic [COUNT_WIDTH-1:0] capture_reg;
  logic                   four_prev_reg;
  logic [IRQ_WIDTH-1:0]   irq_status_reg;
  logic [IRQ_WIDTH-1:0]   irq_mask_reg;
  logic                   irq_reg;
  // apb answer
  logic [31:0]            prdata_reg;
  logic                   pready_reg;
  logic                   pslverr_reg;
  // decoded controls
  logic                   capture_cfg;
  logic                   index_mode;
  logic                   four_rise;
  logic                   capture_hit;
  logic                   index_hit;
  logic                   run_b;
  logic                   wr_en;
  logic                   setup;
  logic                   addr_ok;
  logic [IRQ_WIDTH-1:0]   irq_set;
  logic [IRQ_WIDTH-1:0]   irq_clr;
  // register selects
  logic                   hit_ctrl;
  logic                   hit_count_a;
  logic                   hit_count_b;
  logic                   hit_irq_status;
  logic                   hit_irq_mask;
  // counter results
  logic [COUNT_WIDTH-1:0] counter_unit_a;
  logic [COUNT_WIDTH-1:0] counter_unit_b;
  logic                   wrap_a;
  logic                   wrap_b;
  logic                   load_a;
  logic                   load_b;

  assign pins = {count_input_four, count_input_three,
                 count_input_two, count_input_one};

  // one fast-filtered copy per pin feeds both uses
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_line
      line_filter #(
        .STABLE_CYCLES (FILTER_CYC)
      ) u_filter (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_in    (pins[gi]),
        .level_out (fast_level[gi])
      );
    end
  endgenerate

  // microsecond tick keeps the 1 ms delay counters narrow
  // limitation: the plain delay may run up to one tick short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg == TICK_LAST) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
      tick_reg     <= 1'b0;
    end
  end

  // slow plain-input delay; a bounce restarts the wait
  // reads the fast level, so spikes dropped there never restart it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 4; i++) begin
        delay_cnt_reg[i] <= '0;
      end
      plain_input_line_reg <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (fast_level[i] == plain_input_line_reg[i]) begin
          delay_cnt_reg[i] <= '0;
        end else if (tick_reg) begin
          if (delay_cnt_reg[i] == DELAY_LAST) begin
            delay_cnt_reg[i]        <= '0;
            plain_input_line_reg[i] <= fast_level[i];
          end else begin
            delay_cnt_reg[i] <= delay_cnt_reg[i] + 1'b1;
          end
        end
      end
    end
  end

  // indicators follow the evaluated plain level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_reg <= 4'h0;
    end else begin
      led_reg <= plain_input_line_reg;
    end
  end

  // configuration decode
  // counter b gives up line four to capture, so it must not count then
  assign capture_cfg = ctrl_reg[CTRL_CAPTURE_LINE_CFG];
  assign index_mode  = ctrl_reg[CTRL_INDEX_MODE];
  assign run_b       = ctrl_reg[CTRL_RUN_B] & ~capture_cfg;
  assign four_rise   = fast_level[LINE_FOUR] & ~four_prev_reg;
  assign capture_hit = capture_cfg & ~index_mode & four_rise;
  assign index_hit   = capture_cfg & index_mode & four_rise;

  // apb decode: a write lands in the single access cycle; gating with
  // pready_reg keeps an access phase without a setup from writing
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pready_reg & pwrite;

  // one select per writable word, shared by every write path
  assign hit_ctrl       = paddr == ADDR_CTRL;
  assign hit_count_a    = paddr == ADDR_COUNT_A;
  assign hit_count_b    = paddr == ADDR_COUNT_B;
  assign hit_irq_status = paddr == ADDR_IRQ_STATUS;
  assign hit_irq_mask   = paddr == ADDR_IRQ_MASK;

  // a software load takes priority over counting in the same cycle
  assign load_a  = wr_en & hit_count_a;
  assign load_b  = wr_en & hit_count_b;
  assign addr_ok = paddr == ADDR_CTRL || paddr == ADDR_COUNT_A ||
                   paddr == ADDR_COUNT_B || paddr == ADDR_CAPTURE ||
                   paddr == ADDR_INPUTS || paddr == ADDR_IRQ_STATUS ||
                   paddr == ADDR_IRQ_MASK;

  // counter a always on lines one and two
  counter_core #(
    .WIDTH (COUNT_WIDTH)
  ) u_count_a (
    .pclk       (pclk),
    .presetn    (presetn),
    .line_a     (fast_level[LINE_ONE]),
    .line_b     (fast_level[LINE_TWO]),
    .run        (ctrl_reg[CTRL_RUN_A]),
    .mode       (ctrl_reg[CTRL_MODE_A +: 2]),
    .edge_sel   (ctrl_reg[CTRL_EDGE_A +: 2]),
    .load       (load_a),
    .load_value (pwdata[COUNT_WIDTH-1:0]),
    .zero       (index_hit),
    .count      (counter_unit_a),
    .wrap       (wrap_a)
  );

  // counter b on lines three and four unless capture is chosen
  // b has no index input: line four is its phase b in normal use
  counter_core #(
    .WIDTH (COUNT_WIDTH)
  ) u_count_b (
    .pclk       (pclk),
    .presetn    (presetn),
    .line_a     (fast_level[LINE_THREE]),
    .line_b     (fast_level[LINE_FOUR]),
    .run        (run_b),
    .mode       (ctrl_reg[CTRL_MODE_B +: 2]),
    .edge_sel   (ctrl_reg[CTRL_EDGE_B +: 2]),
    .load       (load_b),
    .load_value (pwdata[COUNT_WIDTH-1:0]),
    .zero       (1'b0),
    .count      (counter_unit_b),
    .wrap       (wrap_b)
  );

  // capture latch on a rising line four
  // takes counter a as it stood before this edge's own step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      four_prev_reg <= 1'b0;
      capture_reg   <= '0;
    end else begin
      four_prev_reg <= fast_level[LINE_FOUR];
      if (capture_hit) begin
        capture_reg <= counter_unit_a;
      end
    end
  end

  // control and mask written by software
  // capture and inputs words are read-only, so writes there fall away
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= CTRL_RESET;
      irq_mask_reg <= '0;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        ctrl_reg <= pwdata[CTRL_WIDTH-1:0];
      end
      if (hit_irq_mask) begin
        irq_mask_reg <= pwdata[IRQ_WIDTH-1:0];
      end
    end
  end

  // sticky events; a new event wins over a same-cycle clear
  always_comb begin
    irq_set              = '0;
    irq_set[IRQ_CAPTURE] = capture_hit;
    irq_set[IRQ_INDEX]   = index_hit;
    irq_set[IRQ_WRAP_A]  = wrap_a;
    irq_set[IRQ_WRAP_B]  = wrap_b;
  end

  // a one written to a status bit clears it; zeros leave it alone
  assign irq_clr = (wr_en && hit_irq_status) ?
                   pwdata[IRQ_WIDTH-1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_set;
    end
  end

  // level interrupt from a flop, one cycle behind the status
  // trade-off: one cycle of lag buys an output straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // read data and answer prepared in the setup cycle
  // a step during the access cycle shows only on the next read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h0000_0000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~addr_ok;
      prdata_reg  <= 32'h0000_0000;
      if (setup && !pwrite) begin
        case (paddr)
          ADDR_CTRL:       prdata_reg <= 32'(ctrl_reg);
          ADDR_COUNT_A:    prdata_reg <= 32'(counter_unit_a);
          ADDR_COUNT_B:    prdata_reg <= 32'(counter_unit_b);
          ADDR_CAPTURE:    prdata_reg <= 32'(capture_reg);
          ADDR_INPUTS:     prdata_reg <= 32'({fast_level,
                                              plain_input_line_reg});
          ADDR_IRQ_STATUS: prdata_reg <= 32'(irq_status_reg);
          ADDR_IRQ_MASK:   prdata_reg <= 32'(irq_mask_reg);
          default:         prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // outputs straight from flops
  assign prdata     = prdata_reg;
  assign pready     = pready_reg;
  assign pslverr    = pslverr_reg;
  assign status_led = led_reg;
  assign irq        = irq_reg;

endmodule

// >>> pkg/counter_unit_pkg.sv
// Purpose: shared constants for the four-line counter input unit
// Assumes: 200 MHz pclk, 32-bit apb data, word-aligned registers
// Notes:   all times are kept in their own unit, cycles derived here
package counter_unit_pkg;

  // clock and timing
  localparam int unsigned CLK_MHZ         = 200;
  localparam int unsigned FAST_FILTER_NS  = 100;
  localparam int unsigned FAST_CYCLES     = FAST_FILTER_NS * CLK_MHZ / 1000;
  localparam int unsigned MIN_PULSE_NS    = 1000;
  localparam int unsigned MIN_PULSE_CYC   = MIN_PULSE_NS * CLK_MHZ / 1000;
  localparam int unsigned TICK_US         = 1;
  localparam int unsigned TICK_CYCLES     = TICK_US * CLK_MHZ;
  localparam int unsigned PLAIN_DELAY_US  = 1000;
  localparam int unsigned PLAIN_DELAY_TCK = PLAIN_DELAY_US / TICK_US;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL       = 12'h000;
  localparam logic [11:0] ADDR_COUNT_A    = 12'h004;
  localparam logic [11:0] ADDR_COUNT_B    = 12'h008;
  localparam logic [11:0] ADDR_CAPTURE    = 12'h00C;
  localparam logic [11:0] ADDR_INPUTS     = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h014;
  localparam logic [11:0] ADDR_IRQ_MASK   = 12'h018;

  // control field positions
  localparam int unsigned CTRL_MODE_A     = 0;
  localparam int unsigned CTRL_EDGE_A     = 2;
  localparam int unsigned CTRL_MODE_B     = 4;
  localparam int unsigned CTRL_EDGE_B     = 6;
  localparam int unsigned CTRL_RUN_A      = 8;
  localparam int unsigned CTRL_RUN_B      = 9;
  localparam int unsigned CTRL_CAPTURE_LINE_CFG   = 10;
  localparam int unsigned CTRL_INDEX_MODE = 11;
  localparam int unsigned CTRL_WIDTH      = 12;
  localparam logic [11:0] CTRL_RESET      = 12'h000;

  // interrupt status bit positions
  localparam int unsigned IRQ_CAPTURE     = 0;
  localparam int unsigned IRQ_INDEX       = 1;
  localparam int unsigned IRQ_WRAP_A      = 2;
  localparam int unsigned IRQ_WRAP_B      = 3;
  localparam int unsigned IRQ_WIDTH       = 4;

  // counting modes
  typedef enum logic [1:0] {
    MODE_UP_DOWN    = 2'b00,
    MODE_PULSE_DIR  = 2'b01,
    MODE_QUADRATURE = 2'b11,
    MODE_OFF        = 2'b10
  } count_mode_type;

  // counting edge selection
  localparam logic [1:0] EDGE_NONE    = 2'b00;
  localparam logic [1:0] EDGE_RISING  = 2'b01;
  localparam logic [1:0] EDGE_FALLING = 2'b10;
  localparam logic [1:0] EDGE_BOTH    = 2'b11;

  // true when the transition prev->cur is one of the selected edges
  function automatic logic edge_hit(input logic prev, input logic cur,
                                    input logic [1:0] sel);
    edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
  endfunction

endpackage

// >>> rtl/line_filter.sv
// Purpose: synchronise one counter pin and apply the fast glitch filter
// Assumes: pin is asynchronous to pclk
// Notes:   level changes only after STABLE_CYCLES of steady new value
`timescale 1ns/1ps
module line_filter
  import counter_unit_pkg::*;
#(
  parameter int unsigned STABLE_CYCLES = FAST_CYCLES
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  localparam int unsigned CW = $clog2(STABLE_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(STABLE_CYCLES - 1);

  logic [1:0]    sync_reg;
  logic [CW-1:0] cnt_reg;
  logic          level_reg;

  // two-flop synchroniser, first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_reg <= 2'h0;
    end else begin
      sync_reg <= {sync_reg[0], pin_in};
    end
  end

  // short stability window: passes 1 us pulses, drops spikes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg   <= '0;
      level_reg <= 1'b0;
    end else if (sync_reg[1] == level_reg) begin
      cnt_reg <= '0;
    end else if (cnt_reg == LAST) begin
      cnt_reg   <= '0;
      level_reg <= sync_reg[1];
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign level_out = level_reg;

endmodule

// >>> rtl/counter_core.sv
// Purpose: one counter with up/down, pulse/direction and quadrature modes
// Assumes: line_a and line_b already filtered and synchronous
// Notes:   load beats index clear, which beats counting
`timescale 1ns/1ps
module counter_core
  import counter_unit_pkg::*;
#(
  parameter int unsigned WIDTH = 32
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // counting lines and setup
  input  wire logic             line_a,
  input  wire logic             line_b,
  input  wire logic             run,
  input  wire logic [1:0]       mode,
  input  wire logic [1:0]       edge_sel,
  // software load and index clear
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             zero,
  // result
  output logic [WIDTH-1:0]      count,
  output logic                  wrap
);

  logic             prev_a_reg;
  logic             prev_b_reg;
  logic [WIDTH-1:0] count_reg;
  logic             wrap_reg;
  logic             up;
  logic             down;

  // step decode per mode
  always_comb begin
    up   = 1'b0;
    down = 1'b0;
    case (mode)
      MODE_UP_DOWN: begin
        up   = edge_hit(prev_a_reg, line_a, edge_sel);
        down = edge_hit(prev_b_reg, line_b, edge_sel);
      end
      MODE_PULSE_DIR: begin
        if (edge_hit(prev_a_reg, line_a, edge_sel)) begin
          up   = line_b;
          down = ~line_b;
        end
      end
      MODE_QUADRATURE: begin
        // one phase changed: sign from phase order
        if ((line_a ^ prev_a_reg) ^ (line_b ^ prev_b_reg)) begin
          up   = line_a ^ prev_b_reg;
          down = ~(line_a ^ prev_b_reg);
        end
      end
      default: begin
        up   = 1'b0;
        down = 1'b0;
      end
    endcase
  end

  // previous line levels for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_a_reg <= 1'b0;
      prev_b_reg <= 1'b0;
    end else begin
      prev_a_reg <= line_a;
      prev_b_reg <= line_b;
    end
  end

  // value update; simultaneous up and down cancel
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= '0;
      wrap_reg  <= 1'b0;
    end else if (load) begin
      count_reg <= load_value;
      wrap_reg  <= 1'b0;
    end else if (zero) begin
      count_reg <= '0;
      wrap_reg  <= 1'b0;
    end else if (run && (up != down)) begin
      count_reg <= up ? count_reg + 1'b1 : count_reg - 1'b1;
      wrap_reg  <= up ? (&count_reg) : ~(|count_reg);
    end else begin
      wrap_reg <= 1'b0;
    end
  end

  assign count = count_reg;
  assign wrap  = wrap_reg;

endmodule

// >>> sim/counter_unit_checker.sv
// Purpose: port-level checks for the counter input unit
// Assumes: apb slave with zero wait states, mapped words up to 0x18
// Notes:   pins are held far longer than the plain input delay
`timescale 1ns/1ps
module counter_unit_checker (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pin one and its indicator
  input wire logic        count_input_one,
  input wire logic [3:0]  status_led
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // setup cycle of a transfer, and one aimed past the last register
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence bad_addr_s;
    setup_s ##0 (paddr > 12'h018);
  endsequence

  zero_wait_a: assert property (setup_s |=> pready)
    else $error("ready missing after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  bad_addr_a: assert property (bad_addr_s |=> pslverr && prdata == 32'h0)
    else $error("unmapped address not refused");
  good_addr_a: assert property (setup_s ##0
    (paddr <= 12'h018 && paddr[1:0] == 2'b00) |=> !pslverr)
    else $error("mapped address refused");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  // the plain level must have been steady well before the light follows
  led_rise_a: assert property ($rose(status_led[0]) |->
    $past(count_input_one, 1) && $past(count_input_one, 8))
    else $error("indicator rose too early");
  led_fall_a: assert property ($fell(status_led[0]) |->
    !$past(count_input_one, 1) && !$past(count_input_one, 8))
    else $error("indicator fell too early");
endmodule

// >>> sim/field_source.sv
// Purpose: field pulse source driving the four counter pins
// Assumes: every level is held for the minimum pulse width
// Notes:   pins are always driven, so the pull-ups never show
`timescale 1ns/1ps
module field_source
  import counter_unit_pkg::*;
(
  // clock
  input wire logic   pclk,
  // pins
  output logic [3:0] pins
);
  initial pins = 4'h0;

  // one level change, held a full width so no edge is lost
  task automatic put(input int i, input logic v);
    @(posedge pclk);
    pins[i] <= v;
    repeat (MIN_PULSE_CYC) @(posedge pclk);
  endtask

  // one complete pulse on line i
  task automatic pulse(input int i);
    put(i, 1'b1);
    put(i, 1'b0);
  endtask

  // one quadrature step on lines i, i+1; forward means phase a leads
  task automatic quad(input int i, input bit fwd);
    if ((pins[i] == pins[i+1]) == fwd) put(i, !pins[i]);
    else put(i + 1, !pins[i+1]);
  endtask

  // whole pattern at once, for plain input reads
  task automatic all(input logic [3:0] v);
    @(posedge pclk);
    pins <= v;
    repeat (MIN_PULSE_CYC) @(posedge pclk);
  endtask
endmodule

// >>> sim/dual_counter_input_unit_test.sv
// Purpose: self-checking bench for the dual counter input unit
// Assumes: plain input delay shortened to 3 ticks of 4 cycles
// Notes:   reads queue their expectation, a monitor compares them
`timescale 1ns/1ps
module dual_counter_input_unit_test
  import counter_unit_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pins, status_led;
  logic [32:0] exp_q[$];
  int          fail_count, checked, cycles, seed, n;

  // 200 MHz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  dual_counter_input_unit #(.TICK_CYC(4), .DELAY_TICKS(3)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .count_input_one(pins[0]),
    .count_input_two(pins[1]), .count_input_three(pins[2]),
    .count_input_four(pins[3]), .status_led(status_led), .irq(irq));
  field_source src_u (.pclk(pclk), .pins(pins));

  // one comparison, counted
  task automatic report(input logic [32:0] got, input logic [32:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one apb transfer; the idle edge after it keeps drives single per step
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // read with expected {error, data}
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask

  // monitor: each completed read takes the oldest expectation
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0)
      report({pslverr, prdata}, exp_q.pop_front());
  end

  // hang guard, far above the roughly 15000 cycles of the run
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      summarize();
    end
  end

  initial begin
    seed = 3;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values, unmapped word, read-only word
    for (int i = 0; i < 7; i++) rd(12'(4 * i), 33'h0);
    rd(12'h01C, 33'h1_0000_0000);
    apb(1'b1, ADDR_INPUTS, 32'hFF);
    rd(ADDR_INPUTS, 33'h0);
    $display("test map done");
    // up/down on counter a for each counting edge
    for (int e = 1; e < 4; e++) begin
      apb(1'b1, ADDR_CTRL, 32'h100 | (e << CTRL_EDGE_A));
      apb(1'b1, ADDR_COUNT_A, 32'h0);
      repeat (3) src_u.pulse(0);
      src_u.pulse(1);
      src_u.put(0, 1'b1);
      rd(ADDR_COUNT_A, 33'((e == 3) ? 5 : 4 - e));
      src_u.put(0, 1'b0);
    end
    $display("test edges done");
    // pulse/direction down through zero, wrap interrupt
    apb(1'b1, ADDR_CTRL, 32'h105);
    apb(1'b1, ADDR_COUNT_A, 32'h0);
    src_u.put(1, 1'b1);
    src_u.pulse(0);
    src_u.put(1, 1'b0);
    repeat (2) src_u.pulse(0);
    rd(ADDR_COUNT_A, 33'hFFFF_FFFF);
    rd(ADDR_IRQ_MASK, 33'h0);
    report(33'(irq), 33'h0);
    apb(1'b1, ADDR_IRQ_MASK, 32'h4);
    rd(ADDR_IRQ_STATUS, 33'h4);
    report(33'(irq), 33'h1);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h4);
    rd(ADDR_IRQ_STATUS, 33'h0);
    report(33'(irq), 33'h0);
    $display("test direction done");
    // quadrature on counter b: back through zero, six forward, one back
    apb(1'b1, ADDR_CTRL, 32'h230);
    src_u.quad(2, 1'b0);
    repeat (6) src_u.quad(2, 1'b1);
    src_u.quad(2, 1'b0);
    rd(ADDR_COUNT_B, 33'h4);
    rd(ADDR_COUNT_A, 33'hFFFF_FFFF);
    rd(ADDR_IRQ_STATUS, 33'h8);
    report(33'(irq), 33'h0);
    apb(1'b1, ADDR_IRQ_STATUS, 32'h8);
    $display("test quadrature done");
    // capture configuration: line four latches, then clears, b stays
    n = ($random(seed) & 7) + 1;
    apb(1'b1, ADDR_CTRL, 32'h744);
    apb(1'b1, ADDR_COUNT_A, 32'h0);
    apb(1'b1, ADDR_COUNT_B, 32'h0);
    repeat (n) src_u.pulse(0);
    src_u.pulse(2);
    src_u.pulse(3);
    rd(ADDR_CAPTURE, 33'(n));
    rd(ADDR_COUNT_B, 33'h0);
    rd(ADDR_IRQ_STATUS, 33'h1);
    apb(1'b1, ADDR_CTRL, 32'hF44);
    src_u.pulse(3);
    rd(ADDR_COUNT_A, 33'h0);
    rd(ADDR_IRQ_STATUS, 33'h3);
    $display("test capture done");
    // plain levels, fast levels and indicators from random patterns
    repeat (3) begin
      n = $random(seed);
      src_u.all(n[3:0]);
      rd(ADDR_INPUTS, 33'({n[3:0], n[3:0]}));
      report(33'(status_led), 33'(n[3:0]));
    end
    $display("test plain inputs done");
    summarize();
  end
endmodule

bind dual_counter_input_unit counter_unit_checker chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .count_input_one(count_input_one), .status_led(status_led));
